// ==== logic/vpic_ctrl.sv ====
// Top of the vectored priority interrupt controller with its register file.
// Functional notes
// R1: Each source has a request flag set by hardware and held until software clears it.
// R2: A source takes part in arbitration only when its enable bit is one.
// R3: Each source has a three-bit priority field choosing one of eight levels.
// R4: On a request the vector goes into an 8-bit field and the level into a 4-bit field of the test status register.
// R5: The captured level equals the priority of the pending request.
// R6: Flags, enables and priorities are laid out in vector order, vector 0 at bit 0 and bits 2 to 0.
// R7: CPU status bits 7 to 5 hold the low CPU level bits and are writable by software.
// R8: Core control bit 3 is the CPU level MSB and is read-only to software.
// R9: Level codes map to 0 to 7 or 8 to 15 with the MSB set, and code 111 blocks all user requests.
// R10: While nesting disable is one the CPU level bits ignore software writes.
// R11: Global control A holds nesting disable and trap flags; B holds external edge and alternate table controls.
// R12: Enable register 4 holds reset-zero enables at bits 13, 8, 3, 2 and 1.
// R13: Unimplemented bits read as zero and ignore writes.
// R14: The highest-priority flagged and enabled source is presented only above the CPU level, ties to lowest vector.
`timescale 1ns/1ps
`default_nettype none
module vpic_ctrl
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [vpic_pkg::AW-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [15:0] rdata,
   input wire logic [vpic_pkg::NUM_SRC-1:0] src_event,
   input wire logic [15:0] enable4_event,
   input wire logic [4:0] trap_event,
   input wire logic cpu_level_msb_in,
   output logic irq_req,
   output logic [7:0] irq_vector,
   output logic [3:0] irq_level,
   output logic [3:0] cpu_priority_level,
   output logic alternate_vector_table,
   output logic irq
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   vpic_pkg::bus_req_s bus;
   vpic_pkg::request_s win;
   vpic_pkg::arb_state_e state_q;
   logic [vpic_pkg::NUM_SRC-1:0] request_flag_regs_q;
   logic [vpic_pkg::NUM_SRC-1:0] enable_regs_q;
   logic [vpic_pkg::NUM_SRC*3-1:0] priority_regs_q;
   logic [15:0] cpu_alu_status_q;
   logic cpu_level_msb_q;
   logic [15:0] global_ctrl_a_q;
   logic [15:0] global_ctrl_b_q;
   logic [15:0] irq_enable_group4_q;
   logic [15:0] enable4_flag_q;
   logic [7:0] captured_vector_q;
   logic [3:0] captured_level_q;
   logic [vpic_pkg::EV_BITS-1:0] ev_status_q;
   logic [vpic_pkg::EV_BITS-1:0] ev_mask_q;
   logic [vpic_pkg::EV_BITS-1:0] ev_set;
   logic [3:0] cpu_level;
   logic nesting_disable;
   logic [15:0] rdata_d;

   assign bus = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};
   assign nesting_disable = global_ctrl_a_q[vpic_pkg::NEST_DIS_BIT];
   assign cpu_level = {cpu_level_msb_q, cpu_alu_status_q[vpic_pkg::CPU_LEVEL_LSB +: 3]}; // see R8, R9

   // ----------------------------------------------------------------
   // Request flags
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         request_flag_regs_q <= '0;
      end
      else
      begin
         // Hardware set wins over a software clear in the same cycle.
         if (bus.wr && bus.addr == vpic_pkg::OFF_FLAG0)
         begin
            request_flag_regs_q <= bus.wdata | src_event; // see R1, R6
         end
         else
         begin
            request_flag_regs_q <= request_flag_regs_q | src_event; // see R1
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         enable4_flag_q <= '0;
      end
      else
      begin
         enable4_flag_q <= enable4_flag_q | (enable4_event & vpic_pkg::ENABLE4_MASK); // see R1
         if (bus.wr && bus.addr == vpic_pkg::OFF_IRQ_STATUS + 8'h04 + 8'h04)
         begin
            enable4_flag_q <= (bus.wdata | enable4_event) & vpic_pkg::ENABLE4_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // Enables and priorities
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         enable_regs_q <= '0;
         irq_enable_group4_q <= '0;
         priority_regs_q <= '0;
      end
      else if (bus.wr)
      begin
         if (bus.addr == vpic_pkg::OFF_ENABLE0)
         begin
            enable_regs_q <= bus.wdata; // see R2, R6
         end
         else if (bus.addr == vpic_pkg::OFF_ENABLE4)
         begin
            irq_enable_group4_q <= bus.wdata & vpic_pkg::ENABLE4_MASK; // see R12, R13
         end
         else if (bus.addr == vpic_pkg::OFF_PRIO0)
         begin
            priority_regs_q[11:0] <= {bus.wdata[14:12], bus.wdata[10:8], bus.wdata[6:4], bus.wdata[2:0]}; // see R3, R6
         end
         else if (bus.addr == vpic_pkg::OFF_PRIO1)
         begin
            priority_regs_q[23:12] <= {bus.wdata[14:12], bus.wdata[10:8], bus.wdata[6:4], bus.wdata[2:0]}; // see R3
         end
         else if (bus.addr == vpic_pkg::OFF_PRIO2)
         begin
            priority_regs_q[35:24] <= {bus.wdata[14:12], bus.wdata[10:8], bus.wdata[6:4], bus.wdata[2:0]}; // see R3
         end
         else if (bus.addr == vpic_pkg::OFF_PRIO3)
         begin
            priority_regs_q[47:36] <= {bus.wdata[14:12], bus.wdata[10:8], bus.wdata[6:4], bus.wdata[2:0]}; // see R3
         end
      end
   end

   // ----------------------------------------------------------------
   // CPU level and global controls
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cpu_alu_status_q <= '0;
      end
      else if (bus.wr && bus.addr == vpic_pkg::OFF_CPU_STATUS)
      begin
         if (nesting_disable)
         begin
            cpu_alu_status_q <= (bus.wdata & vpic_pkg::CPU_STATUS_MASK & 16'hff1f)
               | (cpu_alu_status_q & 16'h00e0); // see R10
         end
         else
         begin
            cpu_alu_status_q <= bus.wdata & vpic_pkg::CPU_STATUS_MASK; // see R7, R13
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cpu_level_msb_q <= 1'b0;
      end
      else
      begin
         cpu_level_msb_q <= cpu_level_msb_in; // see R8
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         global_ctrl_a_q <= '0;
         global_ctrl_b_q <= '0;
      end
      else
      begin
         global_ctrl_a_q[4:1] <= global_ctrl_a_q[4:1] | trap_event[4:1]; // see R11
         if (bus.wr && bus.addr == vpic_pkg::OFF_GCTRL_A)
         begin
            global_ctrl_a_q <= (bus.wdata & vpic_pkg::GCTRL_A_MASK) | {11'h000, trap_event[4:1], 1'b0}; // see R11, R13
         end
         if (bus.wr && bus.addr == vpic_pkg::OFF_GCTRL_B)
         begin
            global_ctrl_b_q <= bus.wdata & vpic_pkg::GCTRL_B_MASK; // see R11, R13
         end
      end
   end

   // ----------------------------------------------------------------
   // Arbitration and capture
   // ----------------------------------------------------------------
   vpic_arbiter u_arb
   (
      .flags(request_flag_regs_q),
      .enables(enable_regs_q),
      .prios(priority_regs_q),
      .cpu_level(cpu_level),
      .winner(win)
   );

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= vpic_pkg::ARB_IDLE;
         captured_vector_q <= '0;
         captured_level_q <= '0;
         irq_req <= 1'b0;
         irq_vector <= '0;
         irq_level <= '0;
      end
      else
      begin
         irq_req <= win.valid; // see R14
         irq_vector <= win.vector;
         irq_level <= win.level;
         case (state_q)
            vpic_pkg::ARB_IDLE:
            begin
               if (win.valid)
               begin
                  state_q <= vpic_pkg::ARB_PEND;
                  captured_vector_q <= win.vector; // see R4
                  captured_level_q <= win.level; // see R4, R5
               end
            end
            vpic_pkg::ARB_PEND:
            begin
               if (!win.valid)
               begin
                  state_q <= vpic_pkg::ARB_IDLE;
               end
               else
               begin
                  captured_vector_q <= win.vector; // see R4
                  captured_level_q <= win.level; // see R5
               end
            end
            default:
            begin
               state_q <= vpic_pkg::ARB_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Event status, mask and interrupt line
   // ----------------------------------------------------------------
   assign ev_set = {win.valid && irq_req && win.vector != irq_vector, win.valid && !irq_req};

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ev_status_q <= '0;
         ev_mask_q <= '0;
      end
      else
      begin
         if (bus.wr && bus.addr == vpic_pkg::OFF_IRQ_STATUS)
         begin
            ev_status_q <= (ev_status_q & ~bus.wdata[vpic_pkg::EV_BITS-1:0]) | ev_set;
         end
         else
         begin
            ev_status_q <= ev_status_q | ev_set;
         end
         if (bus.wr && bus.addr == vpic_pkg::OFF_IRQ_MASK)
         begin
            ev_mask_q <= bus.wdata[vpic_pkg::EV_BITS-1:0];
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq <= 1'b0;
         cpu_priority_level <= '0;
         alternate_vector_table <= 1'b0;
      end
      else
      begin
         irq <= |(ev_status_q & ev_mask_q);
         cpu_priority_level <= cpu_level;
         alternate_vector_table <= global_ctrl_b_q[15];
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_comb
   begin
      rdata_d = 16'h0000;
      if (bus.addr == vpic_pkg::OFF_FLAG0)
      begin
         rdata_d = request_flag_regs_q;
      end
      else if (bus.addr == vpic_pkg::OFF_ENABLE0)
      begin
         rdata_d = enable_regs_q;
      end
      else if (bus.addr == vpic_pkg::OFF_PRIO0 || bus.addr == vpic_pkg::OFF_PRIO1
         || bus.addr == vpic_pkg::OFF_PRIO2 || bus.addr == vpic_pkg::OFF_PRIO3)
      begin
         for (int g = 0; g < 4; g++)
         begin
            if (bus.addr == vpic_pkg::OFF_PRIO0 + 8'(g * 4))
            begin
               for (int k = 0; k < 4; k++)
               begin
                  rdata_d[k*4 +: 3] = priority_regs_q[(g*4+k)*3 +: 3]; // see R13
               end
            end
         end
      end
      else if (bus.addr == vpic_pkg::OFF_CPU_STATUS)
      begin
         rdata_d = cpu_alu_status_q;
      end
      else if (bus.addr == vpic_pkg::OFF_CORE_CTRL)
      begin
         rdata_d[vpic_pkg::CPU_LEVEL_MSB_BIT] = cpu_level_msb_q; // see R8
      end
      else if (bus.addr == vpic_pkg::OFF_GCTRL_A)
      begin
         rdata_d = global_ctrl_a_q;
      end
      else if (bus.addr == vpic_pkg::OFF_GCTRL_B)
      begin
         rdata_d = global_ctrl_b_q;
      end
      else if (bus.addr == vpic_pkg::OFF_TEST_STATUS)
      begin
         rdata_d = {4'h0, captured_level_q, captured_vector_q}; // see R4
      end
      else if (bus.addr == vpic_pkg::OFF_ENABLE4)
      begin
         rdata_d = irq_enable_group4_q;
      end
      else if (bus.addr == vpic_pkg::OFF_IRQ_STATUS)
      begin
         rdata_d = {14'h0000, ev_status_q};
      end
      else if (bus.addr == vpic_pkg::OFF_IRQ_MASK)
      begin
         rdata_d = {14'h0000, ev_mask_q};
      end
      else if (bus.addr == vpic_pkg::OFF_IRQ_STATUS + 8'h08)
      begin
         rdata_d = enable4_flag_q;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= bus.rd ? rdata_d : 16'h0000;
      end
   end
endmodule // vpic_ctrl
`default_nettype wire

// ==== logic/vpic_pkg.sv ====
// Shared constants and types for the vectored priority interrupt controller.
`default_nettype none
package vpic_pkg;
   localparam int unsigned NUM_SRC = 16;
   localparam int unsigned AW = 8;
   localparam logic [7:0] OFF_FLAG0 = 8'h00;
   localparam logic [7:0] OFF_ENABLE0 = 8'h04;
   localparam logic [7:0] OFF_PRIO0 = 8'h08;
   localparam logic [7:0] OFF_PRIO1 = 8'h0c;
   localparam logic [7:0] OFF_PRIO2 = 8'h10;
   localparam logic [7:0] OFF_PRIO3 = 8'h14;
   localparam logic [7:0] OFF_CPU_STATUS = 8'h18;
   localparam logic [7:0] OFF_CORE_CTRL = 8'h1c;
   localparam logic [7:0] OFF_GCTRL_A = 8'h20;
   localparam logic [7:0] OFF_GCTRL_B = 8'h24;
   localparam logic [7:0] OFF_TEST_STATUS = 8'h28;
   localparam logic [7:0] OFF_ENABLE4 = 8'h2c;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h34;
   localparam int unsigned CPU_LEVEL_LSB = 5;
   localparam int unsigned CPU_LEVEL_MSB_BIT = 3;
   localparam int unsigned NEST_DIS_BIT = 15;
   localparam logic [15:0] CPU_STATUS_MASK = 16'h01ff;
   localparam logic [15:0] GCTRL_A_MASK = 16'h801e;
   localparam logic [15:0] GCTRL_B_MASK = 16'hc01f;
   localparam logic [15:0] ENABLE4_MASK = 16'h210e;
   localparam logic [2:0] CPU_LEVEL_ALL_OFF = 3'h7;
   localparam logic [1:0] EV_NEW_REQ = 2'h0;
   localparam logic [1:0] EV_VEC_CHANGE = 2'h1;
   localparam int unsigned EV_BITS = 2;
   typedef struct packed {
      logic valid;
      logic [7:0] vector;
      logic [3:0] level;
   } request_s;
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;
   typedef enum logic [0:0] {
      ARB_IDLE = 1'b0,
      ARB_PEND = 1'b1
   } arb_state_e;
endpackage
`default_nettype wire

// ==== logic/vpic_arbiter.sv ====
// Priority arbiter picking the highest-level flagged and enabled source.
`timescale 1ns/1ps
`default_nettype none
module vpic_arbiter
(
   input wire logic [vpic_pkg::NUM_SRC-1:0] flags,
   input wire logic [vpic_pkg::NUM_SRC-1:0] enables,
   input wire logic [vpic_pkg::NUM_SRC*3-1:0] prios,
   input wire logic [3:0] cpu_level,
   output vpic_pkg::request_s winner
);
   logic [2:0] best;
   logic found;
   always_comb
   begin
      winner = '0;
      best = 3'h0;
      found = 1'b0;
      // Strict greater-than keeps the lowest vector on ties.
      for (int i = 0; i < vpic_pkg::NUM_SRC; i++)
      begin
         if (flags[i] && enables[i] && (!found || prios[i*3 +: 3] > best)) // see R2, R14
         begin
            found = 1'b1;
            best = prios[i*3 +: 3];
            winner.vector = 8'(i);
         end
      end
      winner.level = {1'b0, best}; // see R5
      // A level of zero never interrupts; level must exceed the CPU level.
      winner.valid = found && ({1'b0, best} > cpu_level); // see R9, R14
   end
endmodule // vpic_arbiter
`default_nettype wire

// ==== testbench/vpic_periph_model.sv ====
// Peripheral model that raises request pulses toward the controller.
`timescale 1ns/1ps
`default_nettype none
module vpic_periph_model
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic fire,
   input wire logic [15:0] fire_mask,
   output logic [15:0] src_event
);
   // -----------------------------------------------
   // One-cycle set pulse for each selected source.
   // -----------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn)
         src_event <= 16'h0000;
      else
         src_event <= fire ? fire_mask : 16'h0000;
endmodule // vpic_periph_model
`default_nettype wire

// ==== testbench/vpic_ctrl_checker.sv ====
// Port-level assertion checker for the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module vpic_ctrl_checker
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [vpic_pkg::AW-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [15:0] rdata,
   input wire logic [vpic_pkg::NUM_SRC-1:0] src_event,
   input wire logic [15:0] enable4_event,
   input wire logic [4:0] trap_event,
   input wire logic cpu_level_msb_in,
   input wire logic irq_req,
   input wire logic [7:0] irq_vector,
   input wire logic [3:0] irq_level,
   input wire logic [3:0] cpu_priority_level,
   input wire logic alternate_vector_table,
   input wire logic irq
);
   // ------------------
   // Properties.
   // ------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic nest_q;
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn)
         nest_q <= 1'b0;
      else if (wr_en && addr == vpic_pkg::OFF_GCTRL_A)
         nest_q <= wdata[vpic_pkg::NEST_DIS_BIT];
   sequence s_open_wr;
      !nest_q && wr_en && addr == vpic_pkg::OFF_CPU_STATUS;
   endsequence
   sequence s_locked_wr;
      nest_q && wr_en && addr == vpic_pkg::OFF_CPU_STATUS;
   endsequence
   property p_unmapped;
      rd_en && addr == 8'hfc |=> rdata == 16'h0000;
   endproperty
   property p_level_msb;
      irq_req |-> irq_level[3] == 1'b0;
   endproperty
   property p_above_cpu;
      irq_req && $stable(cpu_priority_level) |-> irq_level > cpu_priority_level;
   endproperty
   property p_all_off;
      cpu_priority_level[2:0] == 3'h7 [*2] |-> !irq_req;
   endproperty
   property p_msb_follow;
      $stable(cpu_level_msb_in) [*3] |-> cpu_priority_level[3] == cpu_level_msb_in;
   endproperty
   property p_cpu_write;
      s_open_wr ##1 !wr_en |=> cpu_priority_level[2:0] == $past(wdata[7:5], 2);
   endproperty
   property p_nest_hold;
      s_locked_wr |=> $stable(cpu_priority_level[2:0]) [*2];
   endproperty
   property p_irq_cause;
      $rose(irq) |-> $past(irq_req) || $past(wr_en, 2);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_level_msb: assert property (p_level_msb)
      else $error("request level above seven");
   a_above_cpu: assert property (p_above_cpu)
      else $error("request not above cpu level");
   a_all_off: assert property (p_all_off)
      else $error("request while user level blocked");
   a_msb_follow: assert property (p_msb_follow)
      else $error("cpu level msb not from core");
   a_cpu_write: assert property (p_cpu_write)
      else $error("cpu level write lost");
   a_nest_hold: assert property (p_nest_hold)
      else $error("cpu level changed while locked");
   a_irq_cause: assert property (p_irq_cause)
      else $error("irq rose without request");
endmodule // vpic_ctrl_checker
bind vpic_ctrl vpic_ctrl_checker u_chk (.core_clk(core_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .src_event(src_event), .enable4_event(enable4_event),
   .trap_event(trap_event), .cpu_level_msb_in(cpu_level_msb_in), .irq_req(irq_req), .irq_vector(irq_vector),
   .irq_level(irq_level), .cpu_priority_level(cpu_priority_level),
   .alternate_vector_table(alternate_vector_table), .irq(irq));
`default_nettype wire

// ==== testbench/tb_vpic_ctrl.sv ====
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module tb_vpic_ctrl;
   `define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
   // ------------------
   // Signals and tasks.
   // ------------------
   logic core_clk, resetn, wr_en, rd_en, fire, msb, irq_req, avt, irq;
   logic [7:0] addr, irq_vector;
   logic [15:0] wdata, rdata, src_event, e4, fmask, seed, en, fl;
   logic [4:0] trap;
   logic [3:0] irq_level, cpl, cl;
   logic [12:0] w;
   logic [2:0] pr [16];
   int n_errors, comparisons;
   vpic_periph_model periph (.core_clk(core_clk), .resetn(resetn), .fire(fire), .fire_mask(fmask),
      .src_event(src_event));
   vpic_ctrl dut (.core_clk(core_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .src_event(src_event), .enable4_event(e4), .trap_event(trap),
      .cpu_level_msb_in(msb), .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
      .cpu_priority_level(cpl), .alternate_vector_table(avt), .irq(irq));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [12:0] expect_win(input logic [15:0] f, input logic [3:0] c);
      logic [12:0] r;
      r = '0;
      for (int v = 0; v < 16; v++)
         if (f[v] && {1'b0, pr[v]} > c && (!r[12] || {1'b0, pr[v]} > r[3:0]))
            r = {1'b1, 8'(v), 1'b0, pr[v]};
      return r;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      `CHK(nm, e, rdata)
   endtask
   task automatic print_verdict();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial
   begin
      #200000;
      n_errors++;
      print_verdict();
   end
   // ------------------
   // Main sequence.
   // ------------------
   initial
   begin
      {resetn, wr_en, rd_en, fire, msb, addr, wdata, e4, fmask, trap} = '0;
      seed = 16'h001c;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      rd(vpic_pkg::OFF_ENABLE4, 16'h0000, "enable4_rst");
      wr(vpic_pkg::OFF_ENABLE4, 16'hffff);
      rd(vpic_pkg::OFF_ENABLE4, 16'h210e, "enable4");
      wr(8'hfc, 16'hffff);
      rd(8'hfc, 16'h0000, "unmapped");
      wr(vpic_pkg::OFF_CORE_CTRL, 16'hffff);
      rd(vpic_pkg::OFF_CORE_CTRL, 16'h0000, "core_ctrl");
      wr(vpic_pkg::OFF_CPU_STATUS, 16'hffff);
      rd(vpic_pkg::OFF_CPU_STATUS, 16'h01ff, "cpu_status");
      wr(vpic_pkg::OFF_GCTRL_A, 16'h8000);
      wr(vpic_pkg::OFF_CPU_STATUS, 16'h0000);
      rd(vpic_pkg::OFF_CPU_STATUS, 16'h00e0, "cpu_locked");
      @(posedge core_clk);
      trap <= 5'h1e;
      e4 <= 16'hffff;
      @(posedge core_clk);
      trap <= 5'h00;
      e4 <= 16'h0000;
      rd(vpic_pkg::OFF_GCTRL_A, 16'h801e, "gctrl_a");
      rd(8'h38, 16'h210e, "group4_flags");
      wr(vpic_pkg::OFF_GCTRL_A, 16'h0000);
      wr(vpic_pkg::OFF_GCTRL_B, 16'h8000);
      @(posedge core_clk);
      #1;
      `CHK("alt_table", 1'b1, avt)
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         en = seed;
         seed = lfsr(seed);
         fl = seed;
         for (int v = 0; v < 16; v++)
            pr[v] = (i == 1) ? 3'h5 : 3'(seed >> (v % 14));
         cl = (i == 0) ? 4'h7 : (i == 1) ? 4'h0 : {i == 2, seed[2:0]};
         wr(vpic_pkg::OFF_ENABLE0, en);
         msb <= cl[3];
         for (int k = 0; k < 4; k++)
            wr(vpic_pkg::OFF_PRIO0 + 8'(4 * k), {1'b0, pr[4*k+3], 1'b0, pr[4*k+2], 1'b0, pr[4*k+1], 1'b0, pr[4*k]});
         wr(vpic_pkg::OFF_CPU_STATUS, {8'h00, cl[2:0], 5'h00});
         wr(vpic_pkg::OFF_IRQ_MASK, {15'h0000, i[0]});
         @(posedge core_clk);
         fmask <= fl;
         fire <= 1'b1;
         @(posedge core_clk);
         fire <= 1'b0;
         repeat (4) @(posedge core_clk);
         #1;
         w = expect_win(fl & en, cl);
         `CHK("cpu_level", cl, cpl)
         `CHK("irq_req", w[12], irq_req)
         `CHK("irq", w[12] & i[0], irq)
         if (w[12])
         begin
            `CHK("irq_vector", w[11:4], irq_vector)
            `CHK("irq_level", w[3:0], irq_level)
            rd(vpic_pkg::OFF_TEST_STATUS, {4'h0, w[3:0], w[11:4]}, "test_status");
         end
         rd(vpic_pkg::OFF_FLAG0, fl, "flags");
         wr(vpic_pkg::OFF_FLAG0, 16'h0000);
         wr(vpic_pkg::OFF_IRQ_STATUS, 16'h0003);
         repeat (2) @(posedge core_clk);
         #1;
         `CHK("irq_req_clear", 1'b0, irq_req)
         `CHK("irq_clear", 1'b0, irq)
      end
      wr(vpic_pkg::OFF_CPU_STATUS, 16'h0000);
      msb <= 1'b0;
      wr(vpic_pkg::OFF_ENABLE0, 16'hffff);
      wr(vpic_pkg::OFF_PRIO0, 16'h0021);
      wr(vpic_pkg::OFF_IRQ_MASK, 16'h0002);
      wr(vpic_pkg::OFF_FLAG0, 16'h0001);
      wr(vpic_pkg::OFF_FLAG0, 16'h0003);
      repeat (3) @(posedge core_clk);
      #1;
      `CHK("irq_vec_change", 1'b1, irq)
      `CHK("irq_vector_new", 8'h01, irq_vector)
      rd(vpic_pkg::OFF_IRQ_STATUS, 16'h0003, "event_status");
      rd(vpic_pkg::OFF_TEST_STATUS, 16'h0201, "test_status_new");
      print_verdict();
   end
endmodule // tb_vpic_ctrl
`default_nettype wire
